// *** rtl/eep_regs.svh ***
// Constants for the serial memory slave: codes, widths and timing counts
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH
`define EEP_DEV_CODE 4'ha
`define EEP_ADDR_W 16
`define EEP_MEM_DEPTH 65536
`define EEP_ADDR_MAX 16'hffff
`define EEP_PAGE_MASK 16'hff80
`define EEP_PAGE_BYTES 128
`define EEP_WRITE_MS 5
`define EEP_CLK_MHZ 200
`define EEP_WRITE_CYC (`EEP_WRITE_MS * `EEP_CLK_MHZ * 1000)
`endif

// *** rtl/eep_pkg.sv ***
// Types shared by the serial memory slave files
package eep_pkg;
    typedef enum logic [2:0] {
        EEP_IDLE, EEP_CTRL, EEP_ADRH, EEP_ADRL, EEP_WDATA, EEP_RDATA, EEP_RACK, EEP_IGNORE
    } eep_state_e;
    typedef enum logic [1:0] {
        EEP_PH_RX, EEP_PH_ACK, EEP_PH_TX, EEP_PH_MACK
    } eep_phase_e;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } eep_bus_ev_s;
    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } eep_sda_drv_s;
endpackage

// *** rtl/eep_bus_cond.sv ***
// Bus condition detector: START, STOP and clock edges from sampled pins
`timescale 1ns/100ps
`default_nettype none
module eep_bus_cond (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output var eep_pkg::eep_bus_ev_s o_ev
);
    import eep_pkg::*;
    // Previous samples of both lines
    typedef struct packed {
        logic scl;
        logic sda;
    } eep_cond_st_s;
    eep_cond_st_s st_q, st_d;
    // Next state is just the current pin levels
    always_comb begin
        st_d.scl = i_scl;
        st_d.sda = i_sda;
    end
    // Idle bus is high on both lines
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end
    // Conditions only count while the clock line stays high
    always_comb begin
        o_ev.start = st_q.scl && i_scl && st_q.sda && !i_sda;
        o_ev.stop = st_q.scl && i_scl && !st_q.sda && i_sda;
        o_ev.rise = !st_q.scl && i_scl;
        o_ev.fall = st_q.scl && !i_scl;
        o_ev.sda = i_sda;
    end
endmodule
`default_nettype wire

// *** rtl/eep_slave.sv ***
// Two-wire serial memory slave with write protect, busy polling and reads
// How it works
// - Protect pin high blocks every array write
// - Protect level captured at write STOP
// - Later protect changes leave cycle unchanged
// - Write STOP starts timed programming cycle
// - No acknowledge at all while programming
// - After programming, matching control byte acknowledged
// - Direction bit one selects a read
// - Address counter holds last access plus one, wrapping within the page after writes
// - Read control acknowledged, then eight bits out
// - Master no-acknowledge then STOP ends read
// - Restart after address loads pointer, no programming
// - After random read, pointer past read byte
// - Master acknowledge advances to next byte
// - Pointer wraps from top to bottom
// - Respond only to type code and select pins
// - Protected write acknowledged, no cycle started
// - After master no-acknowledge, data line released
`timescale 1ns/100ps
`default_nettype none
`include "eep_regs.svh"
module eep_slave #(
    parameter int unsigned WRITE_CYC = `EEP_WRITE_CYC // Programming cycles
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_write_protect,
    input wire logic i_select_pin_high,
    input wire logic i_select_pin_mid,
    input wire logic i_select_pin_low,
    output logic o_busy
);
    import eep_pkg::*;

    // Memory array, kept outside the state struct
    logic [7:0] mem_q [0:`EEP_MEM_DEPTH-1];
    // Page buffer of pending write bytes
    logic [7:0] page_q [0:`EEP_PAGE_BYTES-1];

    // All control state of the slave
    typedef struct packed {
        eep_state_e st;
        eep_phase_e ph;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [15:0] ptr;
        logic [15:0] wbase;
        logic [7:0] wcount;
        logic rd_dir;
        logic wr_pend;
        logic busy;
        logic [31:0] busy_cnt;
        logic sda_oe;
        logic [7:0] rdata;
    } eep_st_s;
    eep_st_s q, d;

    eep_bus_ev_s ev;
    logic match;
    logic [7:0] ctrl_byte;
    logic pg_we;
    logic [6:0] pg_idx;
    logic prog_go;
    // Pulses on each fetch of a read byte from the array
    logic rd_load;

    // Bus condition detection
    eep_bus_cond u_eep_bus_cond (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_ev(ev)
    );

    // Pointer advance with natural 16-bit wrap
    function automatic logic [15:0] eep_inc(input logic [15:0] a);
        eep_inc = a + 16'h0001;
    endfunction

    // Control byte as completed by the bit now sampled
    assign ctrl_byte = {q.shift[6:0], ev.sda};
    assign match = (ctrl_byte[7:4] == `EEP_DEV_CODE)
        && (ctrl_byte[3:1] == {i_select_pin_high, i_select_pin_mid, i_select_pin_low});

    // Next-state logic for the whole protocol
    always_comb begin
        d = q;
        pg_we = 1'b0;
        pg_idx = q.ptr[6:0];
        prog_go = 1'b0;
        rd_load = 1'b0;
        // Programming timer runs independent of bus traffic
        if (q.busy) begin
            if (q.busy_cnt >= WRITE_CYC - 1) begin
                d.busy = 1'b0;
                d.busy_cnt = '0;
            end else begin
                d.busy_cnt = q.busy_cnt + 32'h1;
            end
        end
        if (ev.start) begin
            // Restart drops any pending write but keeps the loaded pointer
            d.st = EEP_CTRL;
            d.ph = EEP_PH_RX;
            d.bit_cnt = '0;
            d.wr_pend = 1'b0;
            d.wcount = '0;
            d.sda_oe = 1'b0;
        end else if (ev.stop) begin
            // Protect level sampled here only; later toggles are ignored
            if (q.wr_pend && q.wcount != 8'h00 && !i_write_protect) begin
                d.busy = 1'b1;
                d.busy_cnt = '0;
                prog_go = 1'b1;
            end
            d.st = EEP_IDLE;
            d.wr_pend = 1'b0;
            d.sda_oe = 1'b0;
        end else if (q.st != EEP_IDLE && q.st != EEP_IGNORE) begin
            if (ev.rise) begin
                case (q.ph)
                    EEP_PH_RX: begin
                        d.shift = ctrl_byte;
                        d.bit_cnt = q.bit_cnt + 3'd1;
                        if (q.bit_cnt == 3'd7) begin
                            d.ph = EEP_PH_ACK;
                            if (q.st == EEP_CTRL) begin
                                // Busy device stays silent on own address
                                if (!match || q.busy) begin
                                    d.st = EEP_IGNORE;
                                end else begin
                                    d.rd_dir = ctrl_byte[0];
                                end
                            end
                        end
                    end
                    EEP_PH_MACK: begin
                        // Master acknowledge marks the next byte as wanted
                        if (!ev.sda) begin
                            d.bit_cnt = 3'd1;
                        end else begin
                            d.st = EEP_IGNORE;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (ev.fall) begin
                case (q.ph)
                    EEP_PH_ACK: begin
                        // Drive acknowledge low for the ninth clock
                        if (!q.sda_oe) begin
                            d.sda_oe = 1'b1;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.bit_cnt = '0;
                            d.ph = EEP_PH_RX;
                            case (q.st)
                                EEP_CTRL: begin
                                    if (q.rd_dir) begin
                                        d.st = EEP_RDATA;
                                        d.ph = EEP_PH_TX;
                                        d.rdata = mem_q[q.ptr];
                                        rd_load = 1'b1;
                                        d.ptr = eep_inc(q.ptr);
                                        d.sda_oe = !mem_q[q.ptr][7];
                                        d.bit_cnt = 3'd1;
                                    end else begin
                                        d.st = EEP_ADRH;
                                    end
                                end
                                EEP_ADRH: d.st = EEP_ADRL;
                                EEP_ADRL: d.st = EEP_WDATA;
                                default: d.st = q.st;
                            endcase
                        end
                    end
                    EEP_PH_TX: begin
                        // Bits already on the line; zero means all eight are out
                        if (q.bit_cnt == 3'd0) begin
                            d.sda_oe = 1'b0;
                            d.ph = EEP_PH_MACK;
                        end else begin
                            // Released for ones, pulled low for zeros
                            d.sda_oe = !q.rdata[3'd7 - q.bit_cnt];
                            d.bit_cnt = q.bit_cnt + 3'd1;
                        end
                    end
                    EEP_PH_MACK: begin
                        // Fetch waits for the fall so data never moves while clock is high
                        if (q.bit_cnt == 3'd1) begin
                            d.ph = EEP_PH_TX;
                            d.rdata = mem_q[q.ptr];
                            d.ptr = eep_inc(q.ptr);
                            d.sda_oe = !mem_q[q.ptr][7];
                            rd_load = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Received address and data bytes
        if (!ev.start && !ev.stop && ev.fall && q.ph == EEP_PH_ACK && !q.sda_oe) begin
            case (q.st)
                EEP_ADRH: d.ptr = {q.shift, q.ptr[7:0]};
                EEP_ADRL: begin
                    d.ptr = {q.ptr[15:8], q.shift};
                    d.wbase = {q.ptr[15:8], q.shift};
                end
                EEP_WDATA: begin
                    pg_we = 1'b1;
                    d.wr_pend = 1'b1;
                    d.ptr = (q.ptr & `EEP_PAGE_MASK) | ((q.ptr + 16'h1) & ~`EEP_PAGE_MASK);
                    if (q.wcount != 8'(`EEP_PAGE_BYTES)) begin
                        d.wcount = q.wcount + 8'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{st: EEP_IDLE, ph: EEP_PH_RX, default: '0};
        end else begin
            q <= d;
        end
    end

    // Page capture and array programming; array content has no reset
    always_ff @(posedge i_clk) begin
        if (pg_we) begin
            page_q[pg_idx] <= q.shift;
        end
        if (prog_go) begin
            for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
                if (8'(i) < q.wcount) begin
                    mem_q[(q.wbase & `EEP_PAGE_MASK) | 16'((q.wbase + 16'(i)) & 16'h7f)]
                        <= page_q[7'((q.wbase + 16'(i)) & 16'h7f)];
                end
            end
        end
    end

    // Open-drain data line: only ever pulls low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = q.sda_oe;
    assign o_busy = q.busy;

    // Protected write never starts programming
    wp_blocks_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (ev.stop && i_write_protect && !q.busy) |=> !q.busy)
        else $error("write started while protected");
    // Busy device never pulls the data line low
    busy_silent_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.busy |-> !o_sda_oe)
        else $error("acknowledge driven while programming");
    // Programming started at STOP lasts at least eight cycles
    prog_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(q.busy) |-> q.busy [*8])
        else $error("programming ended early");
    // Stop releases the line
    stop_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ev.stop |=> !o_sda_oe)
        else $error("line held after stop");
    // Start begins control reception
    start_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ev.start |=> (q.st == EEP_CTRL && q.bit_cnt == 3'd0))
        else $error("start did not restart framing");
    // Mismatched control byte is ignored
    sel_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.st == EEP_CTRL && q.ph == EEP_PH_RX && q.bit_cnt == 3'd7 && ev.rise
         && !ev.start && !ev.stop && !match) |=> q.st == EEP_IGNORE)
        else $error("foreign control byte accepted");
    // Master no-acknowledge releases the line
    nack_free_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.ph == EEP_PH_MACK && ev.rise && ev.sda && !ev.start && !ev.stop
         && q.st == EEP_RDATA) |=> (q.st == EEP_IGNORE && !o_sda_oe))
        else $error("line driven after master no-acknowledge");
    // Ignored slave keeps line released
    ignore_free_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.st == EEP_IGNORE) |-> ##1 (!o_sda_oe || q.st == EEP_CTRL))
        else $error("ignored slave drives line");
    // Programming ends only after its full count
    prog_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(q.busy) |-> ($past(q.busy_cnt) == WRITE_CYC - 1))
        else $error("programming length wrong");
    // Fetch from the top location wraps the pointer to zero
    ptr_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (rd_load && q.ptr == `EEP_ADDR_MAX) |=> (q.ptr == 16'h0000))
        else $error("pointer did not wrap");
endmodule
`default_nettype wire

// *** dv/eep_master.sv ***
// Two-wire bus master model: clock, start, stop and byte transfers
`timescale 1ns/100ps
`default_nettype none
module eep_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe,
    output logic o_res_valid,
    output logic [7:0] o_res
);
    // Idle bus: clock high, data released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_res_valid = 1'b0;
        o_res = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // One-cycle pulse so the monitor sees each value exactly once
    task automatic report(input logic [7:0] v);
        o_res <= v;
        o_res_valid <= 1'b1;
        tick(1);
        o_res_valid <= 1'b0;
    endtask
    // Data changes mid-low, sampled mid-high: never a false condition
    task automatic xfer(input logic b, output logic r);
        o_sda_oe <= ~b;
        tick(3);
        o_scl <= 1'b1;
        tick(3);
        r = i_sda;
        tick(3);
        o_scl <= 1'b0;
        tick(3);
    endtask
    // Also serves as repeated start and as a poll right after stop
    task automatic start();
        o_sda_oe <= 1'b0;
        tick(3);
        o_scl <= 1'b1;
        tick(6);
        o_sda_oe <= 1'b1;
        tick(6);
        o_scl <= 1'b0;
        tick(3);
    endtask
    task automatic stop();
        o_sda_oe <= 1'b1;
        tick(3);
        o_scl <= 1'b1;
        tick(6);
        o_sda_oe <= 1'b0;
        tick(6);
    endtask
    // Byte out, then the slave's acknowledge level is reported
    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(b[i], r);
        xfer(1'b1, ack_n);
        report({7'h00, ack_n});
    endtask
    // Byte in; on a withheld acknowledge the line level is reported too
    task automatic rd_byte(input logic mack);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        report(d);
        xfer(~mack, r);
        if (!mack) report({7'h00, r});
    endtask
endmodule
`default_nettype wire

// *** dv/eeprom_read_poll_protect_test.sv ***
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
`default_nettype none
`include "eep_regs.svh"
module eeprom_read_poll_protect_test;
    import eep_pkg::*;
    localparam int unsigned WCYC = 300; // Short programming cycle
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic wp = 1'b0;
    logic [2:0] sel = 3'h0;
    logic scl, m_oe, s_oe, s_o, busy, res_valid, sda;
    logic [7:0] res;
    logic [15:0] ptr = 16'h0000; // Expected address counter
    logic [7:0] mem [logic [15:0]]; // Expected array content
    logic [7:0] exp_q [$];
    string name_q [$];
    int mismatches = 0;
    int n_compared = 0;
    int seed = 25275;
    int busy_cnt = 0;
    int busy_len = 0;
    // Open-drain data line with pull-up
    assign sda = ~(m_oe | (s_oe & ~s_o));
    initial forever #2.5 i_clk = ~i_clk;
    eep_slave #(.WRITE_CYC(WCYC)) u_eep_slave (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_scl(scl), .i_sda(sda), .o_sda_o(s_o), .o_sda_oe(s_oe), .i_write_protect(wp),
        .i_select_pin_high(sel[2]), .i_select_pin_mid(sel[1]), .i_select_pin_low(sel[0]),
        .o_busy(busy));
    eep_master u_eep_master (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe),
        .o_res_valid(res_valid), .o_res(res));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Busy length measured at each fall; oldest note against each result
    always @(posedge i_clk) begin
        if (busy) busy_cnt <= busy_cnt + 1;
        else if (busy_cnt != 0) begin
            busy_len <= busy_cnt;
            busy_cnt <= 0;
        end
        if (res_valid) begin
            if (exp_q.size() == 0) check("extra result", 32'hffff, {24'h0, res});
            else check(name_q.pop_front(), {24'h0, exp_q.pop_front()}, {24'h0, res});
        end
    end
    task automatic conclude();
        if (exp_q.size() != 0) check("pending notes", 0, exp_q.size());
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [7:0] ctrl(input logic rd);
        return {`EEP_DEV_CODE, sel, rd};
    endfunction
    // Send a byte, noting the acknowledge level expected back
    task automatic wb(input logic [7:0] b, input logic ok);
        logic a;
        name_q.push_back("ack");
        exp_q.push_back(ok ? 8'h00 : 8'h01);
        u_eep_master.wr_byte(b, a);
    endtask
    // Poll after a write: refused while programming, accepted after
    task automatic fin(input logic prog);
        check("busy after stop", prog, busy);
        u_eep_master.start();
        wb(ctrl(1'b0), ~prog);
        u_eep_master.stop();
        if (prog) begin
            for (int k = 0; k < 2000 && busy; k++) u_eep_master.tick(1);
            if (busy) begin
                check("busy timeout", 0, 1);
                conclude();
            end
            u_eep_master.tick(2);
            check("busy cycles", WCYC, busy_len);
            u_eep_master.start();
            wb(ctrl(1'b0), 1'b1);
            u_eep_master.stop();
        end
    endtask
    // Protect level toggled around the stop to prove where it is sampled
    task automatic wr_cmd(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
                          input int n, input logic wps);
        u_eep_master.start();
        wb(ctrl(1'b0), 1'b1);
        wp <= ~wps;
        wb(a[15:8], 1'b1);
        wb(a[7:0], 1'b1);
        for (int i = 0; i < n; i++) begin
            wb(i == 0 ? d0 : d1, 1'b1);
            if (!wps) mem[a + 16'(i)] = i == 0 ? d0 : d1;
        end
        ptr = (a & `EEP_PAGE_MASK) | ((a + 16'(n)) & ~`EEP_PAGE_MASK);
        wp <= wps;
        u_eep_master.stop();
        wp <= ~wps;
        fin(~wps);
        wp <= 1'b0;
    endtask
    // Random read (address set first) or current address read
    task automatic rd(input logic rnd, input logic [15:0] a, input int n);
        u_eep_master.start();
        if (rnd) begin
            wb(ctrl(1'b0), 1'b1);
            wb(a[15:8], 1'b1);
            wb(a[7:0], 1'b1);
            u_eep_master.start();
            ptr = a;
        end
        wb(ctrl(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            name_q.push_back("data");
            exp_q.push_back(mem[ptr]);
            if (i == n - 1) begin
                name_q.push_back("released line");
                exp_q.push_back(8'h01);
            end
            u_eep_master.rd_byte(i < n - 1);
            ptr = ptr + 16'h0001;
        end
        u_eep_master.stop();
    endtask
    // Cut a hang short
    initial begin
        repeat (100000) @(posedge i_clk);
        check("run length", 0, 1);
        conclude();
    end
    initial begin
        logic [15:0] a;
        logic [7:0] d0, d1;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        sel <= 3'($random(seed));
        repeat (3) @(posedge i_clk);
        a = 16'($random(seed)) & 16'hfffe;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        wr_cmd(a, d0, d1, 2, 1'b0);
        rd(1'b1, a, 1);
        rd(1'b0, a, 1);
        $display("test write poll read done");
        wr_cmd(a, ~d0, ~d1, 2, 1'b1);
        rd(1'b1, a, 2);
        $display("test protect done");
        wr_cmd(16'hffff, ~d1, 8'h00, 1, 1'b0);
        wr_cmd(16'h0000, d1, 8'h00, 1, 1'b0);
        rd(1'b1, 16'hffff, 2);
        $display("test wrap done");
        u_eep_master.start();
        wb({`EEP_DEV_CODE, ~sel, 1'b1}, 1'b0);
        u_eep_master.start();
        wb({4'h5, sel, 1'b0}, 1'b0);
        u_eep_master.stop();
        $display("test foreign control done");
        conclude();
    end
endmodule
`default_nettype wire
